// ===== design/asp_pkg.sv
package asp_pkg;

    // frame and configuration word sizes
    localparam logic [5:0]  FRAME_LAST    = 6'h20;
    localparam logic [5:0]  FRAME_MSB     = 6'h1f;
    localparam logic [5:0]  CFG_LAST      = 6'h0d;
    localparam int          CFG_BITS      = 13;

    // configuration word fields, first bit received is the msb
    localparam int          CFG_EN_MSB    = 12;
    localparam int          CFG_EN_LSB    = 10;
    localparam int          CFG_CH_MSB    = 9;
    localparam int          CFG_CH_LSB    = 5;
    localparam int          CFG_EN2       = 4;
    localparam int          CFG_OPT_MSB   = 3;
    localparam logic [2:0]  CFG_ENABLE    = 3'h5;

    // power-on defaults: ch0 +, ch1 -, 50/60 rejection, 1x rate
    localparam logic [4:0]  CHAN_DEFAULT  = 5'h00;
    localparam logic [3:0]  OPT_DEFAULT   = 4'h0;

    // result coding in sub-lsb units, full scale is 2^28
    localparam logic signed [31:0] FS_POS = 32'sh1000_0000;
    localparam logic signed [31:0] FS_NEG = 32'shf000_0000;
    localparam logic [29:0] CODE_OVER     = 30'h3000_0000;
    localparam logic [29:0] CODE_UNDER    = 30'h0fff_ffff;
    localparam int          CODE_SIGN     = 29;
    localparam int          CODE_VAL_MSB  = 28;

    // timing
    localparam int          CLK_PERIOD_NS = 20;
    localparam int          SCK_HALF_NS   = 40;
    localparam int          SCK_HALF_CYC  =
        (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_CONV  = 3'h1,
        ST_SLEEP = 3'h2,
        ST_DATA  = 3'h4
    } asp_state_t;

endpackage : asp_pkg

// ===== design/asp_sync.sv
module asp_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // levels in and out
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] stage1;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1 <= '0;
            dout   <= '0;
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end

endmodule : asp_sync

// ===== design/asp_serial_port.sv
// Contract
// R1 - output bit changes on serial clock fall
// R2 - floating clock selects master, device drives clock
// R3 - clock low at reset/select fall: slave
// R4 - select high: output released, clock ignored
// R5 - select low shows busy/ready status
// R6 - status falls when conversion finishes
// R7 - sleep after conversion until select low
// R8 - 32 bits or late abort starts conversion
// R9 - 32-bit frame, msb first
// R10 - second frame bit always low
// R11 - third bit carries the sign
// R12 - sign and msb flag over/under range
// R13 - result bits 28..5, sub-lsbs 4..0
// R14 - status bit valid at first rising edge
// R15 - output high after 32nd falling edge
// R16 - out-of-range results saturate one lsb beyond
// R17 - input bit sampled on each rising edge; the code stores sdi on rises 1 to 13 only
// R18 - early select rise returns to sleep
// R19 - reset loads default channel and options
// R20 - 13-bit configuration word sets channel, options
// R21 - conversion lasts a set clock count
// R22 - master mode sends exactly 32 pulses
module asp_serial_port #(
    parameter int CONV_CYCLES = 2000,
    parameter int SCK_HALF    = asp_pkg::SCK_HALF_CYC
) (
    // system clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // serial clock as seen on the pin wire
    input  wire logic               sckClk,
    // chip select and data pins
    input  wire logic               csN,
    input  wire logic               sdi,
    output logic                    sdoOut,
    output logic                    sdoOe,
    // serial clock drive in master mode
    output logic                    sckOut,
    output logic                    sckOe,
    // converter core
    input  wire logic signed [31:0] convIn,
    output logic             [4:0]  chanSel,
    output logic             [3:0]  optSel,
    output logic                    convBusy,
    output logic                    masterMode
);

    // ---------------- link side, on the serial clock ----------------
    // select high holds the link side in reset: the clock is ignored
    wire linkRst = rst | csN;

    logic [5:0]  riseCnt;
    logic [5:0]  fallCnt;
    logic [12:0] rxWord;
    logic        startedF;
    logic        fullF;
    logic        doneF;
    logic        sdoReg;
    logic [31:0] frame;
    logic        statusBit;

    wire       rxTake  = riseCnt < asp_pkg::CFG_LAST;
    wire [5:0] fallIdx = asp_pkg::FRAME_MSB - (fallCnt + 6'h01);
    wire       lastFall = (fallCnt + 6'h01) == asp_pkg::FRAME_LAST;
    wire       nextBit  = lastFall ? 1'b1 : frame[fallIdx[4:0]];

    // R17 rising edge sampling
    always_ff @(posedge sckClk or posedge linkRst) begin
        if (linkRst) begin
            riseCnt <= 6'h00;
            rxWord  <= 13'h0000;
        end else begin
            if (riseCnt != asp_pkg::FRAME_LAST)
                riseCnt <= riseCnt + 6'h01;
            if (rxTake)
                rxWord <= {rxWord[11:0], sdi};
        end
    end

    // flags for the crossing come from flops, not from comparators
    always_ff @(posedge sckClk or posedge linkRst) begin
        if (linkRst) begin
            startedF <= 1'b0;
            fullF    <= 1'b0;
        end else begin
            startedF <= 1'b1;
            if (riseCnt == asp_pkg::CFG_LAST - 6'h01)
                fullF <= 1'b1;
        end
    end

    // R1 falling edge shift; a fall before rise 1 only leaves idle
    always_ff @(negedge sckClk or posedge linkRst) begin
        if (linkRst) begin
            fallCnt <= 6'h00;
            sdoReg  <= 1'b0;
            doneF   <= 1'b0;
        end else if (fallCnt != asp_pkg::FRAME_LAST && riseCnt != 6'h00) begin
            fallCnt <= fallCnt + 6'h01;
            sdoReg  <= nextBit;
            doneF   <= lastFall;
        end
    end

    // R14 status bit before first fall
    // R15 high after the last fall
    assign sdoOut = (fallCnt == 6'h00) ? statusBit : sdoReg;

    // ---------------- core side, on clk ----------------
    logic [4:0] syn;
    asp_sync #(.W(5)) u_sync (
        .clk  (clk),
        .rst  (rst),
        .din  ({csN, sckClk, startedF, fullF, doneF}),
        .dout (syn)
    );

    wire csLow    = ~syn[4];
    wire sckLevel = syn[3];
    wire startSyn = syn[2];
    wire fullSyn  = syn[1];
    wire doneSyn  = syn[0];

    asp_pkg::asp_state_t state;
    asp_pkg::asp_state_t next_state;

    logic [31:0] convCnt;
    logic        csLowPrev;
    logic [2:0]  strapWait;
    logic        startSeen;
    logic        cfgGot;
    logic [12:0] cfgWord;
    logic [5:0]  pulseCnt;
    logic [31:0] halfCnt;
    logic        sckLvl;

    wire inConv   = state == asp_pkg::ST_CONV;
    wire inSleep  = state == asp_pkg::ST_SLEEP;
    wire inData   = state == asp_pkg::ST_DATA;
    wire convEnd  = inConv && (convCnt == 32'(CONV_CYCLES - 1));
    wire dataGo   = inSleep && csLow && !doneSyn && !startSyn;
    wire abortReq = inData && !csLow && startSeen;
    wire earlyOut = inData && !csLow && !startSeen && !doneSyn;
    wire startNew = inData && (doneSyn || abortReq);
    wire csFell   = csLow && !csLowPrev;

    // R20 configuration word decode
    wire cfgOn    = cfgWord[asp_pkg::CFG_EN_MSB:asp_pkg::CFG_EN_LSB]
                    == asp_pkg::CFG_ENABLE;
    wire cfgOpt   = cfgOn && cfgWord[asp_pkg::CFG_EN2];

    // R12 range flags
    wire overRng  = convIn >= asp_pkg::FS_POS;
    wire underRng = convIn <  asp_pkg::FS_NEG;
    // R11 sign, zero reads as positive
    // R16 saturation one lsb beyond full scale
    wire [29:0] code = overRng  ? asp_pkg::CODE_OVER  :
                       underRng ? asp_pkg::CODE_UNDER :
                       {~convIn[31], convIn[asp_pkg::CODE_VAL_MSB:0]};

    always_comb begin
        next_state = state;
        case (state)
            asp_pkg::ST_CONV:  if (convEnd)  next_state = asp_pkg::ST_SLEEP;
            // R7 sleep until select low
            asp_pkg::ST_SLEEP: if (dataGo)   next_state = asp_pkg::ST_DATA;
            // R8 new conversion start
            // R18 early rise back to sleep
            asp_pkg::ST_DATA: begin
                if (startNew)
                    next_state = asp_pkg::ST_CONV;
                else if (earlyOut)
                    next_state = asp_pkg::ST_SLEEP;
            end
            default:                         next_state = asp_pkg::ST_CONV;
        endcase
    end

    // R19 reset starts a conversion
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            state <= asp_pkg::ST_CONV;
        else
            state <= next_state;
    end

    // R21 conversion length
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            convCnt <= 32'h0000_0000;
        else if (inConv)
            convCnt <= convCnt + 32'h0000_0001;
        else
            convCnt <= 32'h0000_0000;
    end

    // R9 frame layout
    // R10 fixed zero bit
    // R13 result and sub-lsbs
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            frame <= 32'h0000_0000;
        else if (convEnd)
            frame <= {2'h0, code};
    end

    // R5 status level
    // R6 falls at conversion end
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            statusBit <= 1'b1;
        else
            statusBit <= (next_state == asp_pkg::ST_CONV);
    end
    assign convBusy = statusBit;

    // word is captured while the link holds it still after 13 bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            startSeen <= 1'b0;
            cfgGot    <= 1'b0;
            cfgWord   <= 13'h0000;
        end else if (!inData) begin
            startSeen <= 1'b0;
            cfgGot    <= 1'b0;
        end else begin
            if (startSyn)
                startSeen <= 1'b1;
            if (fullSyn && !cfgGot) begin
                cfgGot  <= 1'b1;
                cfgWord <= rxWord;
            end
        end
    end

    // R19 defaults
    // R20 apply word at next conversion start
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chanSel <= asp_pkg::CHAN_DEFAULT;
            optSel  <= asp_pkg::OPT_DEFAULT;
        end else if (startNew && cfgGot && cfgOn) begin
            chanSel <= cfgWord[asp_pkg::CFG_CH_MSB:asp_pkg::CFG_CH_LSB];
            if (cfgOpt)
                optSel <= cfgWord[asp_pkg::CFG_OPT_MSB:0];
        end
    end

    // R2 floating clock pulls high: master
    // R3 clock low at release or select fall: slave, sync needs 3 edges
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            masterMode <= 1'b0;
            strapWait  <= 3'h0;
            csLowPrev  <= 1'b0;
        end else begin
            strapWait <= {strapWait[1:0], 1'b1};
            csLowPrev <= csLow;
            if (!strapWait[2] || csFell)
                masterMode <= sckLevel;
        end
    end

    // R4 output released while select high
    assign sdoOe = csLow;

    // R22 master clock: 32 pulses, idles low so rise 1 leads the frame
    wire sckRun  = inData && masterMode && csLow
                   && (pulseCnt != asp_pkg::FRAME_LAST);
    wire halfEnd = halfCnt == 32'(SCK_HALF - 1);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            halfCnt  <= 32'h0000_0000;
            sckLvl   <= 1'b0;
            pulseCnt <= 6'h00;
        end else if (!sckRun) begin
            halfCnt <= 32'h0000_0000;
            sckLvl  <= 1'b0;
            if (!inData)
                pulseCnt <= 6'h00;
        end else if (halfEnd) begin
            halfCnt <= 32'h0000_0000;
            sckLvl  <= ~sckLvl;
            if (sckLvl)
                pulseCnt <= pulseCnt + 6'h01;
        end else begin
            halfCnt <= halfCnt + 32'h0000_0001;
        end
    end

    // R2 device drives the clock in master mode while select is low
    assign sckOut = sckLvl;
    assign sckOe  = masterMode && csLow;

    // ---------------- checks ----------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_conv_length: assert property ( // R21
        convEnd |=> !inConv ##1 !convBusy)
        else $error("conversion did not end on count");
    a_sleep_holds: assert property ( // R7
        inSleep && !csLow |=> inSleep)
        else $error("sleep left with select high");
    a_abort_start: assert property ( // R8
        abortReq |=> inConv ##1 convBusy)
        else $error("late abort did not start conversion");
    a_early_sleep: assert property ( // R18
        earlyOut |=> inSleep)
        else $error("early select rise did not return to sleep");
    a_dummy_low: assert property ( // R10
        frame[30] == 1'b0 && frame[31] == 1'b0)
        else $error("fixed zero bit set");
    a_over_code: assert property ( // R12
        convEnd && overRng |=> frame[29:28] == 2'h3)
        else $error("over range not flagged");
    a_under_code: assert property ( // R16
        convEnd && underRng |=> frame[29:0] == asp_pkg::CODE_UNDER)
        else $error("under range not clamped");
    a_pulse_limit: assert property ( // R22
        pulseCnt <= asp_pkg::FRAME_LAST && (inData || !sckOut))
        else $error("master clock ran past frame");
    a_sck_drive: assert property ( // R2
        sckOe |-> masterMode && sdoOe)
        else $error("clock driven outside master select");
    a_status_fall: assert property ( // R6
        convEnd |=> ##1 !statusBit)
        else $error("status did not fall at conversion end");
    // link state is frozen once the last fall is counted
    a_last_high: assert property ( // R15
        fallCnt == asp_pkg::FRAME_LAST && !csN |-> sdoOut)
        else $error("output not high after last fall");

    c_full_frame: cover property (inData && doneSyn);
    c_abort:      cover property (abortReq);
    c_early:      cover property (earlyOut);
    c_master:     cover property (sckOe && sckOut);

endmodule : asp_serial_port

// ===== sim/asp_host_model.sv
module asp_host_model (
    // system clock and link wires
    input  wire logic clk,
    input  wire logic sdoLine,
    input  wire logic sckClk,
    // host drive
    output logic      csN,
    output logic      sdi,
    output logic      sckDrv,
    output logic      sckEn
);
    timeunit 1ns;
    timeprecision 1ps;
    int rises;
    initial begin
        csN = 1'b1;
        sdi = 1'b0;
        sckDrv = 1'b0;
        sckEn = 1'b1;
        rises = 0;
    end
    always @(posedge sckClk) begin
        if (!csN) rises <= rises + 1;
    end
    // clock low at select fall in slave frames, floating high in master; sdi set before each rise
    task automatic frame(input logic [12:0] cfg, input int nRise,
                         input logic master, output logic [31:0] word,
                         output logic first);
        int i;
        word = '0;
        @(negedge clk);
        csN = 1'b0;
        rises = 0;
        repeat (4) @(negedge clk);
        first = sdoLine;
        i = 0;
        while (sdoLine !== 1'b0 && i < 200) begin
            @(negedge clk);
            i++;
        end
        #3.3;
        for (i = 0; i < nRise; i++) begin
            sdi = (i < 13) ? cfg[12-i] : 1'b0;
            if (master) @(posedge sckClk);
            else #6 sckDrv = 1'b1;
            word = {word[30:0], sdoLine};
            if (master) @(negedge sckClk);
            else #6 sckDrv = 1'b0;
        end
        #6;
    endtask : frame
    task automatic release_cs();
        @(negedge clk);
        csN = 1'b1;
        repeat (4) @(negedge clk);
    endtask : release_cs
endmodule : asp_host_model

// ===== sim/asp_serial_port_tb.sv
module asp_serial_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clk;
    logic               rst;
    logic signed [31:0] convIn;
    logic               sdoOut, sdoOe, sckOut, sckOe, convBusy, masterMode;
    logic        [4:0]  chanSel;
    logic        [3:0]  optSel;
    logic               csN, sdi, sckDrv, sckEn, first;
    logic        [31:0] word;
    logic        [12:0] cfg;
    logic        [4:0]  expCh;
    logic        [3:0]  expOpt;
    logic signed [31:0] vals [10];
    wire                sckClk = sckOe ? sckOut : (sckEn ? sckDrv : 1'b1);
    wire                sdoLine = sdoOe ? sdoOut : ~sdoOut;
    int                 err_count, compares, i, seed;

    asp_serial_port #(.CONV_CYCLES(50)) i_dut (
        .clk(clk), .rst(rst), .sckClk(sckClk), .csN(csN), .sdi(sdi),
        .sdoOut(sdoOut), .sdoOe(sdoOe), .sckOut(sckOut), .sckOe(sckOe),
        .convIn(convIn), .chanSel(chanSel), .optSel(optSel),
        .convBusy(convBusy), .masterMode(masterMode));
    asp_host_model i_host (
        .clk(clk), .sdoLine(sdoLine), .sckClk(sckClk), .csN(csN),
        .sdi(sdi), .sckDrv(sckDrv), .sckEn(sckEn));

    initial clk = 1'b0;
    always #10 clk = ~clk;

    function automatic logic [31:0] expF(input logic signed [31:0] v);
        if (v >= asp_pkg::FS_POS) expF = {2'h0, asp_pkg::CODE_OVER};
        else if (v < asp_pkg::FS_NEG) expF = {2'h0, asp_pkg::CODE_UNDER};
        else expF = {2'h0, v >= 0, v[28:0]};
    endfunction : expF

    task automatic chkWord(input string n, input logic [31:0] e,
                           input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chkWord
    task automatic chkBit(input string n, input logic e, input logic g);
        chkWord(n, {31'h0, e}, {31'h0, g});
    endtask : chkBit
    task automatic summarize();
        $display("checks %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    task automatic doRst(input logic master);
        i_host.sckEn = !master;
        rst = 1'b1;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
    endtask : doRst

    initial begin
        #1_000_000;
        err_count++;
        summarize();
    end

    initial begin
        seed = 32'h7b77c054;
        err_count = 0;
        compares = 0;
        vals = '{asp_pkg::FS_POS, asp_pkg::FS_POS - 1, 32'sh0, -32'sh1,
                 asp_pkg::FS_NEG, asp_pkg::FS_NEG - 1, 0, 0, 0, 0};
        for (i = 6; i < 10; i++) vals[i] = $signed($random(seed)) >>> 3;
        rst = 1'b1;
        convIn = vals[0];
        expCh = asp_pkg::CHAN_DEFAULT;
        expOpt = asp_pkg::OPT_DEFAULT;
        doRst(1'b0);
        chkBit("slave strap", 1'b0, masterMode);
        chkWord("chan default", {27'h0, expCh}, {27'h0, chanSel});
        chkWord("opt default", {28'h0, expOpt}, {28'h0, optSel});
        chkBit("sdo released", 1'b0, sdoOe);
        for (i = 0; i < 10; i++) begin
            cfg = $random(seed);
            if (i % 3 != 2) cfg[12:10] = asp_pkg::CFG_ENABLE;
            i_host.frame(cfg, 32, 1'b0, word, first);
            // sign, range codes, saturation and field layout
            chkWord("frame", expF(vals[i]), word);
            chkBit("sdo after 32", 1'b1, sdoLine);
            if (i > 0) chkBit("busy status", 1'b1, first);
            @(negedge clk);
            convIn = vals[(i + 1) % 10];
            i_host.release_cs();
            if (cfg[12:10] == asp_pkg::CFG_ENABLE) begin
                expCh = cfg[asp_pkg::CFG_CH_MSB:asp_pkg::CFG_CH_LSB];
                if (cfg[asp_pkg::CFG_EN2]) expOpt = cfg[3:0];
            end
            chkWord("chan", {27'h0, expCh}, {27'h0, chanSel});
            chkWord("opt", {28'h0, expOpt}, {28'h0, optSel});
        end
        // abort after five rises, short config refused
        i_host.frame(13'h17ff, 5, 1'b0, word, first);
        i_host.release_cs();
        chkBit("abort starts", 1'b1, convBusy);
        chkWord("chan kept", {27'h0, expCh}, {27'h0, chanSel});
        i_host.frame(13'h0, 0, 1'b0, word, first);
        chkBit("abort status", 1'b1, first);
        i_host.release_cs();
        chkBit("early rise sleep", 1'b0, convBusy);
        repeat (5) begin
            #6 i_host.sckDrv = 1'b1;
            #6 i_host.sckDrv = 1'b0;
        end
        chkBit("sck ignored", 1'b0, sdoOe);
        chkBit("sck ignored busy", 1'b0, convBusy);
        i_host.frame(13'h0, 32, 1'b0, word, first);
        chkWord("sleep result", expF(vals[0]), word);
        i_host.release_cs();
        convIn = vals[3];
        doRst(1'b1);
        chkBit("master strap", 1'b1, masterMode);
        i_host.frame(13'h0, 32, 1'b1, word, first);
        repeat (20) @(negedge clk);
        chkWord("master frame", expF(vals[3]), word);
        chkWord("pulses", 32'h20, i_host.rises);
        chkBit("master sdo", 1'b1, sdoLine);
        i_host.release_cs();
        chkBit("sck released", 1'b0, sckOe);
        summarize();
    end
endmodule : asp_serial_port_tb
